//--- modulation_iq_decompressor.v
// Purpose: Expands modulation-compressed downlink IQ words
// Assumes: Sample stream and Avalon master share clock_i
// Notes:   One IQ component per word, I then Q, twelve REs per PRB
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "mod_decomp_defines.vh"

// What this block does
// - Every IQ component is taken from the stream as a raw word of the configured sample width, or of the maximum width when that field is 0 or above it.
// - The raw word is read as a two's complement fraction with one integer bit, giving a value in [-1,1).
// - When the selected shift flag is 1, two to the minus sample width is added, otherwise nothing.
// - In extension 4 mode each RE takes the shift flag and scale of the mask entry with a one at that RE.
// - In extension 5 mode each RE takes the shift flag and alternate scale of the ext5 mask with a one there.
// - The output is the selected scale times the possibly unshifted value times the square root of two.
// - A section holds at most two modulation types, so only two flag and scale pairs exist per PRB.
// - Each scale factor is held with 15 bits of precision.
// - The output magnitude never exceeds one, and one stands for full scale.
// - A shift flag of 1 means unshift the REs, 0 means no correction.
module modulation_iq_decompressor #(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3,
	parameter ROUND_EN = 1,
	parameter SAT_EN = 1
) (
	input wire clock_i,
	input wire reset_n_i,
	input wire [2:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire [15:0] raw_iq_word_i,
	input wire raw_sop_i,
	input wire raw_valid_i,
	output wire raw_ready_o,
	output reg [15:0] scaled_iq_value_o,
	output reg scaled_is_q_o,
	output reg [3:0] scaled_re_index_o,
	output reg scaled_valid_o,
	input wire scaled_ready_i
);

// ----------------------------------------
// Helper functions
// ----------------------------------------

// Byte-lane merge for register writes
function [31:0] merge_be;
	input [31:0] old_v;
	input [31:0] new_v;
	input [3:0] be;
	integer k;
	begin
		merge_be = old_v;
		for (k = 0; k < 4; k = k + 1) begin
			if (be[k]) begin
				merge_be[k*8 +: 8] = new_v[k*8 +: 8];
			end
		end
	end
endfunction

// Byte-lane merge for the 16-bit scale registers
function [15:0] merge_lo;
	input [15:0] old_v;
	input [31:0] new_v;
	input [3:0] be;
	begin
		merge_lo = old_v;
		if (be[0])
			merge_lo[7:0] = new_v[7:0];
		if (be[1])
			merge_lo[15:8] = new_v[15:8];
	end
endfunction

// Mask bit for an RE, RE 0 in the highest mask bit
function mask_hit;
	input [11:0] mask;
	input [3:0] re;
	reg [3:0] pos;
	begin
		pos = `RE_PER_PRB_LAST - re;
		mask_hit = mask[pos];
	end
endfunction

// Widths of 0 or above the maximum fall back to the maximum
function [4:0] eff_width;
	input [4:0] w;
	begin
		if (w == 5'h00 || w > `SAMPLE_MAX_W) begin
			eff_width = `SAMPLE_MAX_W;
		end else begin
			eff_width = w;
		end
	end
endfunction

// 15-bit scale times root two, kept with 15 fraction bits
function [16:0] scale_root2;
	input [14:0] s;
	reg [31:0] p;
	begin
		p = {17'h00000, s} * {16'h0000, `SQRT2_Q2_14};
		scale_root2 = p[30:`SQRT2_FRAC];
	end
endfunction

// ----------------------------------------
// Registers and state
// ----------------------------------------
reg [31:0] ctrl;
reg [31:0] mask4;
reg [31:0] mask5;
reg [15:0] scale4_0;
reg [15:0] scale4_1;
reg [15:0] scale5_0;
reg [15:0] scale5_1;
reg sat_flag;
reg miss_flag;
reg [15:0] sample_count;
reg [3:0] re_idx;
reg comp_q;

wire enable;
wire ext5;
wire [4:0] width;
wire bus_wr;
wire bus_rd;
wire [16:0] fifo_out;
wire fifo_valid;
wire pop;

assign enable = ctrl[`CTRL_ENABLE_BIT];
assign ext5 = ctrl[`CTRL_EXT5_BIT];
assign width = eff_width(ctrl[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB]);
assign bus_wr = avs_write_i & ~avs_waitrequest_o;
assign bus_rd = avs_read_i & avs_waitrequest_o;
// Stalls while disabled or while the output stage is held
assign pop = fifo_valid & enable & (~scaled_valid_o | scaled_ready_i);

// ----------------------------------------
// Input buffering
// ----------------------------------------

// Back-pressure reaches the source through raw_ready_o
iq_word_fifo #(
	.WIDTH(17),
	.DEPTH(FIFO_DEPTH),
	.AW(FIFO_AW)
) u_fifo (
	.clock_i(clock_i),
	.reset_n_i(reset_n_i),
	.in_data_i({raw_sop_i, raw_iq_word_i}),
	.in_valid_i(raw_valid_i),
	.in_ready_o(raw_ready_o),
	.out_data_o(fifo_out),
	.out_valid_o(fifo_valid),
	.out_ready_i(pop)
);

// ----------------------------------------
// Datapath
// ----------------------------------------
reg [3:0] cur_re;
reg cur_q;
reg [11:0] sel_m0;
reg [11:0] sel_m1;
reg [15:0] sel_e0;
reg [15:0] sel_e1;
reg hit0;
reg hit1;
reg [15:0] entry;
reg [31:0] shifted;
reg [15:0] norm;
reg [17:0] samp;
reg [17:0] unshift;
reg [16:0] scale_eff;
reg [35:0] prod;
reg [35:0] rounded;
reg [19:0] whole;
reg [15:0] next_value;
reg next_sat;
reg [3:0] next_re;
reg next_q;

// RE position, restarted by the PRB start marker
always @* begin
	cur_re = fifo_out[16] ? 4'h0 : re_idx;
	cur_q = fifo_out[16] ? 1'b0 : comp_q;
	next_q = ~cur_q;
	next_re = cur_re;
	if (cur_q) begin
		next_re = (cur_re == `RE_PER_PRB_LAST) ? 4'h0 : cur_re + 4'h1;
	end
end

// Pick the flag and scale pair for this RE
always @* begin
	if (ext5) begin
		sel_m0 = mask5[`MASK_E0_MSB:`MASK_E0_LSB];
		sel_m1 = mask5[`MASK_E1_MSB:`MASK_E1_LSB];
		sel_e0 = scale5_0;
		sel_e1 = scale5_1;
	end else begin
		sel_m0 = mask4[`MASK_E0_MSB:`MASK_E0_LSB];
		sel_m1 = mask4[`MASK_E1_MSB:`MASK_E1_LSB];
		sel_e0 = scale4_0;
		sel_e1 = scale4_1;
	end
	hit0 = mask_hit(sel_m0, cur_re);
	hit1 = mask_hit(sel_m1, cur_re);
	// Only two pairs; an RE in neither mask falls back to entry 0
	entry = (hit0 | ~hit1) ? sel_e0 : sel_e1;
end

// Normalise, unshift, scale, round and saturate
always @* begin
	// Keep exactly width bits, MSB aligned as a Q1.15 fraction
	shifted = {16'h0000, fifo_out[15:0]} << (`SAMPLE_MAX_W - width);
	norm = shifted[15:0];
	samp = {norm[15], norm, 1'b0};
	unshift = 18'h00000;
	if (entry[`SCALE_CSF_BIT]) begin
		unshift = 18'h00001 << (`SAMPLE_MAX_W - width);
	end
	samp = samp + unshift;
	scale_eff = scale_root2(entry[`SCALE_MSB:0]);
	prod = $signed(samp) * $signed({1'b0, scale_eff});
	rounded = prod;
	if (ROUND_EN != 0) begin
		rounded = prod + `ROUND_HALF;
	end
	whole = rounded[35:16];
	next_sat = 1'b0;
	next_value = whole[15:0];
	// Clamp so that the result never exceeds unit magnitude
	if (SAT_EN != 0) begin
		if (!whole[19] && whole[18:15] != 4'h0) begin
			next_value = `OUT_POS_MAX;
			next_sat = 1'b1;
		end else if (whole[19] && whole[18:15] != 4'hF) begin
			next_value = `OUT_NEG_MAX;
			next_sat = 1'b1;
		end
	end
end

// ----------------------------------------
// Output stage and stream position
// ----------------------------------------

// Output words stand until taken by the consumer
always @(posedge clock_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		scaled_valid_o <= 1'b0;
		scaled_iq_value_o <= 16'h0000;
		scaled_is_q_o <= 1'b0;
		scaled_re_index_o <= 4'h0;
		re_idx <= 4'h0;
		comp_q <= 1'b0;
		sample_count <= 16'h0000;
	end else begin
		if (pop) begin
			scaled_valid_o <= 1'b1;
			scaled_iq_value_o <= next_value;
			scaled_is_q_o <= cur_q;
			scaled_re_index_o <= cur_re;
			re_idx <= next_re;
			comp_q <= next_q;
			sample_count <= sample_count + 16'h0001;
		end else if (scaled_ready_i) begin
			scaled_valid_o <= 1'b0;
		end
	end
end

// ----------------------------------------
// Avalon slave
// ----------------------------------------

// One wait cycle per access, answer in the next cycle
always @(posedge clock_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		avs_waitrequest_o <= 1'b1;
		avs_readdata_o <= 32'h0000_0000;
	end else begin
		if ((avs_read_i | avs_write_i) && avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
		if (bus_rd) begin
			case (avs_address_i)
				`REG_CTRL: avs_readdata_o <= ctrl;
				`REG_MASK4: avs_readdata_o <= mask4;
				`REG_MASK5: avs_readdata_o <= mask5;
				`REG_SCALE4_0: avs_readdata_o <= {16'h0000, scale4_0};
				`REG_SCALE4_1: avs_readdata_o <= {16'h0000, scale4_1};
				`REG_SCALE5_0: avs_readdata_o <= {16'h0000, scale5_0};
				`REG_SCALE5_1: avs_readdata_o <= {16'h0000, scale5_1};
				`REG_STATUS: avs_readdata_o <= {sample_count, 14'h0000, miss_flag, sat_flag};
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end
end

// Configuration writes; unused bits are kept at zero
always @(posedge clock_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		ctrl <= `CTRL_RESET;
		mask4 <= `MASK_RESET;
		mask5 <= `MASK_RESET;
		scale4_0 <= `SCALE_RESET;
		scale4_1 <= `SCALE_RESET;
		scale5_0 <= `SCALE_RESET;
		scale5_1 <= `SCALE_RESET;
	end else if (bus_wr) begin
		case (avs_address_i)
			`REG_CTRL: ctrl <= merge_be(ctrl, avs_writedata_i, avs_byteenable_i) & 32'h0000_1F03;
			`REG_MASK4: mask4 <= merge_be(mask4, avs_writedata_i, avs_byteenable_i) & 32'h0FFF_0FFF;
			`REG_MASK5: mask5 <= merge_be(mask5, avs_writedata_i, avs_byteenable_i) & 32'h0FFF_0FFF;
			`REG_SCALE4_0: scale4_0 <= merge_lo(scale4_0, avs_writedata_i, avs_byteenable_i);
			`REG_SCALE4_1: scale4_1 <= merge_lo(scale4_1, avs_writedata_i, avs_byteenable_i);
			`REG_SCALE5_0: scale5_0 <= merge_lo(scale5_0, avs_writedata_i, avs_byteenable_i);
			`REG_SCALE5_1: scale5_1 <= merge_lo(scale5_1, avs_writedata_i, avs_byteenable_i);
			default: ctrl <= ctrl;
		endcase
	end
end

// ----------------------------------------
// Sticky status
// ----------------------------------------
wire clr_sat;
wire clr_miss;
wire set_sat;
wire set_miss;

assign clr_sat = bus_wr & (avs_address_i == `REG_STATUS) & avs_byteenable_i[0]
	& avs_writedata_i[`STAT_SAT_BIT];
assign clr_miss = bus_wr & (avs_address_i == `REG_STATUS) & avs_byteenable_i[0]
	& avs_writedata_i[`STAT_MISS_BIT];
assign set_sat = pop & next_sat;
assign set_miss = pop & ~hit0 & ~hit1;

// Write one to clear; a new event in the same cycle wins
always @(posedge clock_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		sat_flag <= 1'b0;
		miss_flag <= 1'b0;
	end else begin
		sat_flag <= set_sat | (sat_flag & ~clr_sat);
		miss_flag <= set_miss | (miss_flag & ~clr_miss);
	end
end

endmodule // modulation_iq_decompressor

`default_nettype wire

//--- mod_decomp_defines.vh
// Purpose: Shared constants for the modulation decompressor
// Assumes: Register index is the Avalon word address
// Notes:   Byte address of a register is four times its index
`ifndef MOD_DECOMP_DEFINES_VH
`define MOD_DECOMP_DEFINES_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define REG_CTRL     3'h0
`define REG_MASK4    3'h1
`define REG_MASK5    3'h2
`define REG_SCALE4_0 3'h3
`define REG_SCALE4_1 3'h4
`define REG_SCALE5_0 3'h5
`define REG_SCALE5_1 3'h6
`define REG_STATUS   3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_EXT5_BIT   1
`define CTRL_WIDTH_LSB  8
`define CTRL_WIDTH_MSB  12
`define MASK_E0_LSB     0
`define MASK_E0_MSB     11
`define MASK_E1_LSB     16
`define MASK_E1_MSB     27
`define SCALE_MSB       14
`define SCALE_CSF_BIT   15
`define STAT_SAT_BIT    0
`define STAT_MISS_BIT   1
`define STAT_COUNT_LSB  16

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define CTRL_RESET      32'h0000_1001
`define MASK_RESET      32'h0000_0FFF
`define SCALE_RESET     16'h4000
`define SAMPLE_MAX_W    5'h10
`define RE_PER_PRB_LAST 4'hB
`define SQRT2_Q2_14     16'h5A82
`define SQRT2_FRAC      14
`define OUT_POS_MAX     16'h7FFF
`define OUT_NEG_MAX     16'h8000
`define ROUND_HALF      36'h0_0000_8000

`endif

//--- iq_word_fifo.v
// Purpose: Small synchronous FIFO for raw sample words
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Room and empty are registered so ready and valid are flops
`timescale 1ns/1ns
`default_nettype none

module iq_word_fifo #(
	parameter WIDTH = 17,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clock_i,
	input wire reset_n_i,
	input wire [WIDTH-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i
);

reg [WIDTH-1:0] store [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
reg room;
reg empty;
wire push;
wire pop;
wire [AW:0] next_count;

assign in_ready_o = room;
assign out_valid_o = ~empty;
assign out_data_o = store[rd_ptr];
assign push = in_valid_i & room;
assign pop = out_ready_i & ~empty;
assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

// Storage write, no reset needed on data
always @(posedge clock_i) begin
	if (push) begin
		store[wr_ptr] <= in_data_i;
	end
end

// Pointers and flags; wrap assumes DEPTH is a power of two
always @(posedge clock_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		count <= {(AW+1){1'b0}};
		room <= 1'b1;
		empty <= 1'b1;
	end else begin
		if (push) begin
			wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
		end
		if (pop) begin
			rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
		end
		count <= next_count;
		room <= (next_count != DEPTH[AW:0]);
		empty <= (next_count == {(AW+1){1'b0}});
	end
end

endmodule // iq_word_fifo

`default_nettype wire

//--- mod_decomp_checker.sv
// Purpose: Port-level timing checks of the decompressor
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into every decompressor instance
`timescale 1ns/1ns
`default_nettype none
module mod_decomp_checker (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic raw_valid_i,
	input wire logic raw_ready_o,
	input wire logic [15:0] scaled_iq_value_o,
	input wire logic scaled_is_q_o,
	input wire logic [3:0] scaled_re_index_o,
	input wire logic scaled_valid_o,
	input wire logic scaled_ready_i
);
	// ----
	// Bus handshake
	// ----
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	// Request seen while the slave still waits
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	// One low cycle, then high again
	sequence s_ans;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	AST_BUS_ANSWER: assert property (s_req |=> s_ans)
		else $error("bus answer not one cycle after request");
	AST_WAIT_CAUSE: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
		else $error("waitrequest dropped without request");
	AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	// Read data may only move into a read answer cycle
	AST_RDATA_HOLD: assert property ($changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
		else $error("read data changed outside a read");
	// ----
	// Sample stream
	// ----
	AST_OUT_HOLD: assert property (scaled_valid_o && !scaled_ready_i |=> scaled_valid_o
		&& $stable(scaled_iq_value_o) && $stable(scaled_re_index_o) && $stable(scaled_is_q_o))
		else $error("output changed before it was taken");
	AST_RE_RANGE: assert property (scaled_valid_o |-> scaled_re_index_o <= 4'hB)
		else $error("resource element index beyond PRB");
	// Buffer can only fill through an accepted word
	AST_READY_FALL: assert property ($fell(raw_ready_o) |-> $past(raw_valid_i))
		else $error("input ready fell without a word");
	AST_RESET_STATE: assert property ($rose(reset_n_i) |-> avs_waitrequest_o && raw_ready_o && !scaled_valid_o)
		else $error("ports not idle after reset");
endmodule // mod_decomp_checker

bind modulation_iq_decompressor mod_decomp_checker u_chk (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .raw_valid_i(raw_valid_i),
	.raw_ready_o(raw_ready_o), .scaled_iq_value_o(scaled_iq_value_o), .scaled_is_q_o(scaled_is_q_o),
	.scaled_re_index_o(scaled_re_index_o), .scaled_valid_o(scaled_valid_o), .scaled_ready_i(scaled_ready_i)
);
`default_nettype wire

//--- iq_source_model.sv
// Purpose: Far-end source of compressed downlink words
// Assumes: Words are taken on valid and ready at an edge
// Notes:   Idle data shows the inverse of the last word
`timescale 1ns/1ns
`default_nettype none
module iq_source_model (
	input wire logic clock_i,
	input wire logic ready_i,
	output logic [15:0] word_o,
	output logic sop_o,
	output logic valid_o
);
	// ----
	// Word sender
	// ----
	initial begin
		word_o = 16'h0000;
		sop_o = 1'b0;
		valid_o = 1'b0;
	end
	// Downlink only; one width for the whole PRB
	task automatic send(input logic [15:0] w, input logic s, output logic ok);
		int n;
		n = 0;
		@(posedge clock_i);
		word_o <= w;
		sop_o <= s;
		valid_o <= 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (ready_i !== 1'b1 && n < 100);
		ok = (n < 100);
		valid_o <= 1'b0;
		sop_o <= 1'b0;
		word_o <= ~w;
	endtask
endmodule // iq_source_model
`default_nettype wire

//--- tb_modulation_iq_decompressor.sv
// Purpose: Self-checking bench for the modulation decompressor
// Assumes: Source model feeds the stream, bench is consumer
// Notes:   Expected samples come from a reference formula
`timescale 1ns/1ns
`default_nettype none
`include "mod_decomp_defines.vh"
module tb_modulation_iq_decompressor;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [2:0] avs_address_i = 3'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [15:0] raw_iq_word_i;
	logic raw_sop_i;
	logic raw_valid_i;
	logic raw_ready_o;
	logic [15:0] scaled_iq_value_o;
	logic scaled_is_q_o;
	logic [3:0] scaled_re_index_o;
	logic scaled_valid_o;
	logic scaled_ready_i = 1'b1;
	int err_count = 0;
	int checked = 0;
	int cur_w;
	logic [11:0] m0, m1;
	logic [15:0] s0, s1;
	logic [31:0] rd;
	logic [20:0] got[$];
	logic [31:0] rst_val [8] = '{`CTRL_RESET, `MASK_RESET, `MASK_RESET, 32'h4000, 32'h4000, 32'h4000, 32'h4000, 32'h0};

	modulation_iq_decompressor dut (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .raw_iq_word_i(raw_iq_word_i),
		.raw_sop_i(raw_sop_i), .raw_valid_i(raw_valid_i), .raw_ready_o(raw_ready_o),
		.scaled_iq_value_o(scaled_iq_value_o), .scaled_is_q_o(scaled_is_q_o),
		.scaled_re_index_o(scaled_re_index_o), .scaled_valid_o(scaled_valid_o), .scaled_ready_i(scaled_ready_i)
	);
	iq_source_model src (.clock_i(clock_i), .ready_i(raw_ready_o), .word_o(raw_iq_word_i),
		.sop_o(raw_sop_i), .valid_o(raw_valid_i));

	// ----
	// Clock and output monitor
	// ----
	always #5 clock_i = ~clock_i;
	// Record every word the consumer takes
	always @(posedge clock_i) begin
		if (scaled_valid_o === 1'b1 && scaled_ready_i === 1'b1)
			got.push_back({scaled_re_index_o, scaled_is_q_o, scaled_iq_value_o});
	end

	// ----
	// Shared tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results;
		$display("Mismatches %0d of %0d comparisons", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		do begin
			@(posedge clock_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n >= 50) begin
			err_count++;
			results();
		end
	endtask
	// Reference: Q1.(w-1), unshift, times truncated scale-root-two product, round, clip
	function automatic logic [15:0] f_exp(input logic [15:0] r, input logic [15:0] sc);
		logic signed [15:0] t;
		longint x;
		t = r << (16 - cur_w);
		x = 2 * longint'(t >>> (16 - cur_w)) + (sc[15] ? 1 : 0);
		x = x * ((longint'(sc[14:0]) * 64'sh5A82) >>> 14);
		x = (x + (64'sh1 <<< (cur_w - 1))) >>> cur_w;
		if (x > 32767)
			x = 32767;
		if (x < -32768)
			x = -32768;
		return x[15:0];
	endfunction
	function automatic logic [15:0] f_raw(input int n);
		logic [15:0] lim;
		lim = 16'h1 << (cur_w - 1);
		return n == 8 ? lim - 16'h1 : (n == 9 ? lim : (n * 16'h25 + 16'h5) & (lim * 2 - 16'h1));
	endfunction
	// Push n words with junk above the sample width, then judge n outputs
	task automatic run(input int n);
		logic ok;
		logic [3:0] re;
		logic [15:0] sel;
		for (int i = 0; i < n; i++) begin
			src.send(f_raw(i) | (16'h5555 << cur_w), i == 0, ok);
			if (!ok) begin
				chk("source", 1, 0);
				results();
			end
		end
		for (int k = 0; k < 500 && got.size() < n; k++)
			@(posedge clock_i);
		chk("count", n, got.size());
		if (got.size() < n)
			results();
		for (int i = 0; i < n && got.size() > 0; i++) begin
			re = i / 2;
			sel = (m0[11 - re] || !m1[11 - re]) ? s0 : s1;
			chk("sample", {re, i % 2 == 1, f_exp(f_raw(i), sel)}, got.pop_front());
		end
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		for (int i = 0; i < 8; i++) begin
			bus(0, i, 0, 4'hF);
			chk("reset value", rst_val[i], rd);
		end
		bus(1, `REG_MASK4, 32'hFFFF_FFFF, 4'hF);
		bus(0, `REG_MASK4, 0, 4'hF);
		chk("mask reserved", 32'h0FFF_0FFF, rd);
		bus(1, `REG_SCALE4_0, 32'hFFFF_FFFF, 4'hF);
		bus(0, `REG_SCALE4_0, 0, 4'hF);
		chk("scale width", 32'h0000_FFFF, rd);
		bus(1, `REG_CTRL, 32'h0000_0A00, 4'h2);
		bus(0, `REG_CTRL, 0, 4'hF);
		chk("byte lane", 32'h0000_0A01, rd);
	endtask
	// Mode, width, two mask entries and their flag and scale pairs
	task automatic t_stream(input logic ext5, input int w, input logic [11:0] a, b, input logic [15:0] c, d);
		cur_w = w;
		m0 = a;
		m1 = b;
		s0 = c;
		s1 = d;
		bus(1, ext5 ? `REG_MASK5 : `REG_MASK4, {4'h0, b, 4'h0, a}, 4'hF);
		bus(1, ext5 ? `REG_SCALE5_0 : `REG_SCALE4_0, {16'h0, c}, 4'hF);
		bus(1, ext5 ? `REG_SCALE5_1 : `REG_SCALE4_1, {16'h0, d}, 4'hF);
		bus(1, `REG_CTRL, 32'h1 | (w << 8) | (ext5 << 1), 4'hF);
		run(24);
	endtask
	// Disabled block fills the buffer; enable holds one word at the stalled output; release drains it
	task automatic t_fifo;
		logic ok;
		logic [15:0] sel;
		bus(1, `REG_CTRL, 32'h0000_0002, 4'hF); // Width field 0 falls back to full width
		scaled_ready_i <= 1'b0;
		for (int i = 0; i < 8; i++)
			src.send(f_raw(i), i == 0, ok);
		repeat (2) @(posedge clock_i);
		chk("full refuses", 0, raw_ready_o);
		bus(1, `REG_CTRL, 32'h0000_0003, 4'hF);
		repeat (4) @(posedge clock_i);
		chk("held output", 1, scaled_valid_o);
		scaled_ready_i <= 1'b1;
		run(0);
		for (int k = 0; k < 50 && got.size() < 8; k++)
			@(posedge clock_i);
		for (int i = 0; i < 8 && got.size() > 0; i++) begin
			sel = (m0[11 - i / 2] || !m1[11 - i / 2]) ? s0 : s1;
			chk("drained", {i[3:0] >> 1, i % 2 == 1, f_exp(f_raw(i), sel)}, got.pop_front());
		end
		chk("empty ready", 1, raw_ready_o);
	endtask

	// Sticky flags and word count after both streams, then write-one-to-clear
	task automatic t_status;
		bus(0, `REG_STATUS, 0, 4'hF);
		chk("status", 32'h0030_0003, rd);
		bus(1, `REG_STATUS, 32'h3, 4'hF);
		bus(0, `REG_STATUS, 0, 4'hF);
		chk("status clear", 32'h0030_0000, rd);
	endtask

	initial begin
		repeat (3) @(posedge clock_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_stream(0, 3, 12'hF00, 12'h0FF, 16'hC000, 16'h7FFF);
		t_stream(1, 16, 12'h00F, 12'h0F0, 16'h2000, 16'hE000);
		t_status();
		t_fifo();
		results();
	end
endmodule // tb_modulation_iq_decompressor
`default_nettype wire
